// ==== design/ext_bus_ready_hold.sv ====
// Purpose: External bus cycle extension by the wait input and hold arbitration
// Assumes: Wait input in synchronous mode changes with the bus reference clock (MCLK)
// Notes:   Access request is a level held until the done pulse
`timescale 1ns/10ps
`include "ext_bus_defs.svh"

module ext_bus_ready_hold
    import ext_bus_pkg::*;
(
    input  wire logic      MCLK,
    input  wire logic      SYS_RST,
    input  wire bus_cfg_s  CFG,
    input  wire logic      ACC_REQ,
    input  wire logic      ACC_WRITE,
    input  wire logic      READY_PIN,
    input  wire logic      HOLD_N_PIN,
    output logic           ACC_DONE,
    output bus_ctrl_s      BUS_CTRL,
    output logic           BUS_HOLD_GRANT_N,
    output logic           BUS_REGAIN_REQUEST_N
);

    bus_state_e                 state_q;      // Controller state
    bus_state_e                 state_d;      // Next state
    logic [`EB_WAIT_CNT_W-1:0]  wcnt_q;       // Mandatory wait counter
    logic [`EB_WAIT_CNT_W-1:0]  wcnt_d;       // Next wait counter
    logic                       extra_q;      // Asynchronous extra wait pending
    logic                       extra_d;      // Next extra wait flag
    logic                       write_q;      // Direction of the running cycle
    logic                       ready_sync_q; // Single sample for synchronous mode
    logic                       ready_async;  // Filtered asynchronous sample
    logic                       hold_n_lvl;   // Filtered hold request pin
    logic                       ready_raw;    // Sample chosen by mode
    logic                       ready_ok;     // Ready after polarity
    logic                       hold_req;     // Hold request honoured
    logic                       sample_now;   // Sample point reached
    logic                       cmd_end;      // Mandatory waits over
    bus_ctrl_s                  ctrl_q;       // Strobes register
    bus_ctrl_s                  ctrl_d;       // Next strobes
    logic                       done_q;       // Done pulse register
    logic                       grant_n_q;    // Hold grant register
    logic                       bus_regain_request_n_n_q;     // Bus request register
    logic                       bus_regain_request_n_n_d;     // Next bus request
    logic                       write_dir;    // Direction for the next cycle

    // Extra three-stage synchroniser for asynchronous wait input
    pin_sync3 u_ready_sync (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .rst_level (1'h0),
        .pin       (READY_PIN),
        .level     (ready_async)
    );

    // Hold request pin synchroniser
    pin_sync3 u_hold_sync (
        .clk       (MCLK),
        .rst       (SYS_RST),
        .rst_level (1'h1),
        .pin       (HOLD_N_PIN),
        .level     (hold_n_lvl)
    );

    // Mode selects single-flop or synchronised sample; polarity applied after
    assign ready_raw  = CFG.ready_async ? ready_async : ready_sync_q;
    assign ready_ok   = ready_raw ~^ CFG.ready_active_high;
    // Hold honoured only with arbitration pins enabled
    assign hold_req   = CFG.arb_enable & ~hold_n_lvl;
    // Asynchronous mode spends one wait before the first valid sample
    assign sample_now = (state_q == ST_RDY) & ~extra_q;
    assign cmd_end    = (wcnt_q == `EB_WAIT_CNT_RST);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // Hold is granted only between cycles
                if (hold_req) begin
                    state_d = ST_RELEASE;
                end else if (ACC_REQ) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                state_d = ST_CMD;
            end
            ST_CMD: begin
                // Mandatory waits run out before the wait input is used
                if (cmd_end) begin
                    state_d = ST_RDY;
                end
            end
            ST_RDY: begin
                // Ready ends the cycle, otherwise stay one more wait
                if (sample_now && ready_ok) begin
                    state_d = ST_DONE;
                end else begin
                    state_d = ST_RDY;
                end
            end
            ST_DONE: begin
                // Strobe rises here; finished cycle may now yield the bus
                state_d = hold_req ? ST_RELEASE : ST_IDLE;
            end
            ST_RELEASE: begin
                state_d = ST_HELD;
            end
            ST_HELD: begin
                // Only hold deassertion starts the regain
                if (!hold_req) begin
                    state_d = ST_REGAIN;
                end
            end
            ST_REGAIN: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Wait counter loads the programmed phase on the address phase
    assign wcnt_d  = (state_q == ST_ADDR) ? CFG.mandatory_waits :
                     (state_q == ST_CMD && !cmd_end) ? wcnt_q - 2'h1 : wcnt_q;
    // Extra asynchronous wait armed on each entry to the wait-controlled phase
    assign extra_d = (state_q == ST_CMD) ? (CFG.ready_async & `EB_ASYNC_EXTRA_WAITS) : 1'h0;

    // Strobes: address phase raises ALE, command phases pull the strobe low
    assign ctrl_d.ale  = (state_d == ST_ADDR);
    assign ctrl_d.rd_n = ~((state_d == ST_CMD || state_d == ST_RDY) && !write_dir);
    assign ctrl_d.wr_n = ~((state_d == ST_CMD || state_d == ST_RDY) && write_dir);
    // Strobes float only while held; release and regain drive them inactive
    assign ctrl_d.oe_n = (state_d == ST_HELD);

    // Bus request while held and an access waits; withdrawn on regain
    assign bus_regain_request_n_n_d = ~((state_d == ST_HELD) && ACC_REQ);

    // Direction for the next cycle: latched at its start, a named wire keeps sensitivity complete
    assign write_dir = (state_q == ST_IDLE) ? ACC_WRITE : write_q;

    // State and counters
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_q <= ST_IDLE;
            wcnt_q  <= `EB_WAIT_CNT_RST;
            extra_q <= 1'h0;
            write_q <= 1'h0;
        end else begin
            state_q <= state_d;
            wcnt_q  <= wcnt_d;
            extra_q <= extra_d;
            write_q <= write_dir;
        end
    end

    // Synchronous mode sample: one flop, shortest cycle
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ready_sync_q <= 1'h0;
        end else begin
            ready_sync_q <= READY_PIN;
        end
    end

    // Output registers
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ctrl_q    <= '{ale: `EB_ALE_RST, rd_n: `EB_STROBE_RST, wr_n: `EB_STROBE_RST, oe_n: 1'h0};
            done_q    <= 1'h0;
            grant_n_q <= 1'h1;
            bus_regain_request_n_n_q  <= 1'h1;
        end else begin
            ctrl_q    <= ctrl_d;
            done_q    <= (state_d == ST_DONE);
            grant_n_q <= ~(state_d == ST_HELD);
            bus_regain_request_n_n_q  <= bus_regain_request_n_n_d;
        end
    end

    assign BUS_CTRL             = ctrl_q;
    assign ACC_DONE             = done_q;
    assign BUS_HOLD_GRANT_N     = grant_n_q;
    assign BUS_REGAIN_REQUEST_N = bus_regain_request_n_n_q;

endmodule

// ==== design/ext_bus_defs.svh ====
// Purpose: Timing counts and reset values for the bus cycle extension and hold logic
// Assumes: One system clock, MCLK at 100 MHz
// Notes:   Included by the package and by the design modules
`ifndef EXT_BUS_DEFS_SVH
`define EXT_BUS_DEFS_SVH

// Clock period in ns
`define EB_MCLK_PERIOD_NS      10
// Width of the mandatory wait phase counter
`define EB_WAIT_CNT_W          2
// Cycles in the address phase (address latch strobe high)
`define EB_ADDR_CYCLES         2'h1
// Extra wait-controlled cycles before an asynchronous sample is used
`define EB_ASYNC_EXTRA_WAITS   1'h1
// Reset value of the wait counter
`define EB_WAIT_CNT_RST        2'h0
// Reset level of a low-active control strobe
`define EB_STROBE_RST          1'h1
// Reset level of the address latch strobe
`define EB_ALE_RST             1'h0

`endif

// ==== design/ext_bus_pkg.sv ====
// Purpose: Types shared by the bus cycle extension and hold logic
// Assumes: ext_bus_defs.svh gives the numeric constants
// Notes:   States use Gray codes from IDLE through DONE, RELEASE, HELD and REGAIN
`include "ext_bus_defs.svh"

package ext_bus_pkg;

    // Controller states, Gray coded along the cycle and hold path
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ADDR    = 3'h1,
        ST_CMD     = 3'h3,
        ST_RDY     = 3'h2,
        ST_DONE    = 3'h6,
        ST_RELEASE = 3'h7,
        ST_HELD    = 3'h5,
        ST_REGAIN  = 3'h4
    } bus_state_e;

    // Bus control strobes and their common output enable
    typedef struct packed {
        logic ale;     // Address latch strobe, high active
        logic rd_n;    // Read strobe
        logic wr_n;    // Write strobe
        logic oe_n;    // Low while the strobes are driven
    } bus_ctrl_s;

    // Static configuration of the wait logic and arbitration
    typedef struct packed {
        logic                              ready_active_high; // Polarity of the wait input
        logic                              ready_async;       // Extra synchroniser on the wait input
        logic                              arb_enable;        // Arbitration pins in use
        logic [`EB_WAIT_CNT_W-1:0]         mandatory_waits;   // Mandatory wait phase length
    } bus_cfg_s;

endpackage

// ==== design/pin_sync3.sv ====
// Purpose: Three-stage synchroniser for one pin input with agreement filter
// Assumes: The pin is asynchronous to MCLK
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/10ps
`include "ext_bus_defs.svh"

module pin_sync3 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rst_level,
    input  wire logic pin,
    output logic      level
);

    logic s1_q;    // First stage, read only by the second
    logic s2_q;    // Second stage
    logic s3_q;    // Third stage
    logic lvl_q;   // Filtered level
    logic lvl_d;   // Next filtered level

    // Take the new level only when the last two stages agree
    assign lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    assign level = lvl_q;

    // Shift chain; reset loads the idle level given by the caller
    always_ff @(posedge clk) begin
        if (rst) begin
            // Idle level avoids a false request right after reset
            s1_q  <= rst_level;
            s2_q  <= rst_level;
            s3_q  <= rst_level;
            lvl_q <= rst_level;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

endmodule

// ==== verification/ext_bus_ready_hold_asserts.sv ====
// Purpose: Port assertions for the cycle extension and hold logic
// Assumes: CFG stays static while cycles run
// Notes:   Bound to the design from the bench top file
`timescale 1ns/10ps
module ext_bus_ready_hold_asserts
    import ext_bus_pkg::*;
(
    input wire logic      MCLK,
    input wire logic      SYS_RST,
    input wire bus_cfg_s  CFG,
    input wire logic      ACC_REQ,
    input wire logic      HOLD_N_PIN,
    input wire logic      ACC_DONE,
    input wire bus_ctrl_s BUS_CTRL,
    input wire logic      BUS_HOLD_GRANT_N,
    input wire logic      BUS_REGAIN_REQUEST_N
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic       lo;        // A command strobe is low
    logic       drv_idle;  // Strobes driven inactive, latch strobe low
    logic [3:0] lo_q;      // Consecutive strobe-low cycles
    logic [3:0] min_lo;    // Shortest legal strobe-low run
    assign lo = !(BUS_CTRL.rd_n && BUS_CTRL.wr_n);
    assign drv_idle = !BUS_CTRL.oe_n && !lo && !BUS_CTRL.ale;
    assign min_lo = 4'(CFG.mandatory_waits) + 4'h2 + 4'(CFG.ready_async);
    // Count the strobe-low run of the running cycle
    always_ff @(posedge MCLK) begin
        lo_q <= (lo && !SYS_RST) ? lo_q + 4'h1 : 4'h0;
    end
    a_done_pulse: assert property (ACC_DONE |=> !ACC_DONE) else $error("done pulse too long");
    a_done_strobe: assert property (ACC_DONE |-> !lo && $past(lo)) else $error("done without strobe end");
    a_min_wait: assert property (ACC_DONE |-> lo_q >= min_lo) else $error("cycle too short");
    a_grant_float: assert property (!BUS_HOLD_GRANT_N |-> BUS_CTRL.oe_n && !ACC_DONE) else $error("granted but driving");
    a_release_order: assert property ($fell(BUS_HOLD_GRANT_N) |-> $past(drv_idle)) else $error("release order");
    a_regain_order: assert property ($rose(BUS_HOLD_GRANT_N) |-> drv_idle) else $error("regain order");
    a_arb_off: assert property (!CFG.arb_enable |-> BUS_HOLD_GRANT_N) else $error("grant while disabled");
    a_grant_cause: assert property ($fell(BUS_HOLD_GRANT_N) |-> !$past(HOLD_N_PIN, 3)) else $error("grant without hold");
    a_regain_bound: assert property ($rose(HOLD_N_PIN) && !BUS_HOLD_GRANT_N |-> ##[1:8] BUS_HOLD_GRANT_N)
        else $error("regain late");
    a_bus_regain_request_n_held: assert property (!BUS_REGAIN_REQUEST_N |-> !BUS_HOLD_GRANT_N) else $error("request while owner");
    a_bus_regain_request_n_pend: assert property (!BUS_HOLD_GRANT_N && ACC_REQ |=> !BUS_REGAIN_REQUEST_N || BUS_HOLD_GRANT_N)
        else $error("request missing");
    c_done: cover property (ACC_DONE);
    c_grant: cover property ($fell(BUS_HOLD_GRANT_N));
    c_bus_regain_request_n: cover property (!BUS_REGAIN_REQUEST_N);
endmodule

// ==== verification/ext_bus_far_side.sv ====
// Purpose: Far side: wait-state memory and a second bus master
// Assumes: Strobes come from device registers
// Notes:   Ready changes only just after MCLK edges
`timescale 1ns/10ps
module ext_bus_far_side
    import ext_bus_pkg::*;
(
    input  wire logic       clk,
    input  wire bus_ctrl_s  ctrl,
    input  wire logic       act_high,
    input  wire logic [3:0] delay,
    input  wire logic       want_bus,
    output logic            ready_pin,
    output logic            hold_n_pin
);
    logic       sel;           // Strobe low while driven
    logic [3:0] cnt_q = 4'h0;  // Cycles since the strobe fell
    assign sel = !(ctrl.rd_n && ctrl.wr_n) && !ctrl.oe_n;
    // Ready held until the trailing strobe edge, then dropped
    assign ready_pin = (sel && cnt_q >= delay) ~^ act_high;
    // Count strobe-low cycles
    always @(posedge clk) begin
        cnt_q <= sel ? cnt_q + 4'h1 : 4'h0;
    end
    // Other master may release without any request
    assign hold_n_pin = !want_bus;
endmodule

// ==== verification/ext_bus_ready_and_hold_arbitration_bench.sv ====
// Purpose: Self-checking bench for the cycle extension and hold logic
// Assumes: Far-side model answers ready and hold
// Notes:   Table rows for plain cycles, hold cases by hand
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module ext_bus_ready_and_hold_arbitration_bench
    import ext_bus_pkg::*;
;
    typedef struct packed {logic asyn; logic pol; logic [1:0] w; logic [3:0] d; logic wr; logic [7:0] len;} row_s;
    logic       mclk, sys_rst, acc_req, acc_write, want_bus, ready_pin, hold_n_pin, acc_done, grant_n, bus_regain_request_n_n;
    logic [3:0] delay;
    logic [7:0] rd_lo, wr_lo;
    bus_cfg_s   cfg;
    bus_ctrl_s  ctrl;
    int         error_cnt, cmp_count, n;
    // Mode, polarity, waits, ready delay, direction, strobe-low length
    row_s       rows [6] = '{'{0,1,0,0,0,2}, '{0,0,1,0,1,3}, '{0,1,0,3,0,5}, '{0,0,2,1,1,4}, '{1,1,0,0,0,3}, '{1,0,1,2,1,5}};
    ext_bus_ready_hold dut (.MCLK(mclk), .SYS_RST(sys_rst), .CFG(cfg), .ACC_REQ(acc_req), .ACC_WRITE(acc_write),
        .READY_PIN(ready_pin), .HOLD_N_PIN(hold_n_pin), .ACC_DONE(acc_done), .BUS_CTRL(ctrl),
        .BUS_HOLD_GRANT_N(grant_n), .BUS_REGAIN_REQUEST_N(bus_regain_request_n_n));
    ext_bus_far_side far (.clk(mclk), .ctrl(ctrl), .act_high(cfg.ready_active_high), .delay(delay),
        .want_bus(want_bus), .ready_pin(ready_pin), .hold_n_pin(hold_n_pin));
    // Verdict and end of run
    task automatic wrap_up();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One access, counting strobe-low cycles until the done pulse
    task automatic access(input logic wr);
        logic fin;
        fin = 0;
        rd_lo = 0;
        wr_lo = 0;
        acc_write <= wr;
        acc_req <= 1'b1;
        for (int i = 0; i < 60 && !fin; i++) begin
            @(posedge mclk);
            rd_lo += 8'(!ctrl.rd_n);
            wr_lo += 8'(!ctrl.wr_n);
            fin = (acc_done === 1'b1);
        end
        acc_req <= 1'b0;
        `CHK("done", 1'b1, fin)
        @(posedge mclk);
    endtask
    // Clock
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end
    // Main sequence
    initial begin
        sys_rst = 1;
        acc_req = 0;
        acc_write = 0;
        want_bus = 0;
        delay = 0;
        cfg = '{1'b1, 1'b0, 1'b0, 2'h0};
        repeat (4) @(posedge mclk);
        `CHK("rst_ctrl", 4'h6, ctrl)
        `CHK("rst_grant", 2'h3, {grant_n, bus_regain_request_n_n})
        sys_rst <= 0;
        repeat (4) @(posedge mclk);
        foreach (rows[i]) begin
            cfg <= '{rows[i].pol, rows[i].asyn, 1'b0, rows[i].w};
            delay <= rows[i].d;
            repeat (4) @(posedge mclk);
            access(rows[i].wr);
            `CHK("idle_strobe", 8'h0, rows[i].wr ? rd_lo : wr_lo)
            if (rows[i].asyn) `CHK("async_len", 1'b1, rd_lo + wr_lo >= rows[i].len)
            else `CHK("sync_len", rows[i].len, rd_lo + wr_lo)
        end
        // Hold ignored while arbitration is off; ready answers at once
        cfg <= '{1'b1, 1'b0, 1'b0, 2'h0};
        delay <= 4'h0;
        want_bus <= 1;
        repeat (6) @(posedge mclk);
        access(0);
        `CHK("off_len", 8'h2, rd_lo)
        `CHK("off_grant", 1'b1, grant_n)
        // Let the released hold pin pass the synchroniser before enabling arbitration
        want_bus <= 0;
        repeat (6) @(posedge mclk);
        cfg <= '{1'b1, 1'b0, 1'b1, 2'h0};
        delay <= 4'h4;
        repeat (6) @(posedge mclk);
        // Hold arrives mid-cycle: cycle ends first
        fork
            access(1);
            begin
                repeat (3) @(posedge mclk);
                want_bus <= 1;
                repeat (6) @(posedge mclk);
                `CHK("early_grant", 1'b1, grant_n)
            end
        join
        for (n = 0; n < 20 && grant_n !== 1'b0; n++) @(posedge mclk);
        `CHK("grant", 1'b0, grant_n)
        `CHK("float", 1'b1, ctrl.oe_n)
        acc_req <= 1;
        repeat (10) @(posedge mclk);
        `CHK("bus_regain_request_n", 1'b0, bus_regain_request_n_n)
        `CHK("still_held", 1'b0, grant_n)
        want_bus <= 0;
        @(posedge mclk);
        access(0);
        `CHK("regain_len", 8'h6, rd_lo)
        `CHK("bus_regain_request_n_off", 2'h3, {grant_n, bus_regain_request_n_n})
        wrap_up();
    end
endmodule
bind ext_bus_ready_hold ext_bus_ready_hold_asserts chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .CFG(CFG), .ACC_REQ(ACC_REQ),
    .HOLD_N_PIN(HOLD_N_PIN), .ACC_DONE(ACC_DONE), .BUS_CTRL(BUS_CTRL), .BUS_HOLD_GRANT_N(BUS_HOLD_GRANT_N),
    .BUS_REGAIN_REQUEST_N(BUS_REGAIN_REQUEST_N));
